// ---- shared/wdhr_pkg.sv ----
// Constants, register map and state types of the watchdog, halt and reset controller.
`default_nettype none

package wdhr_pkg;

    // Avalon byte offsets of the register words.
    localparam logic [3:0]  WDHR_OFS_SELECT     = 4'h0;
    localparam logic [3:0]  WDHR_OFS_STATUS     = 4'h4;
    localparam logic [3:0]  WDHR_OFS_COMMAND    = 4'h8;
    localparam logic [3:0]  WDHR_OFS_STATE      = 4'hC;

    localparam logic [7:0]  WDHR_SELECT_RESET   = 8'h07;
    localparam int          WDHR_RATIO_LSB      = 0;
    localparam int          WDHR_RATIO_W        = 3;
    localparam int          WDHR_TO_BIT         = 5;
    localparam int          WDHR_PD_BIT         = 4;

    localparam int          WDHR_CMD_CLR_SINGLE = 0;
    localparam int          WDHR_CMD_CLR_FIRST  = 1;
    localparam int          WDHR_CMD_CLR_SECOND = 2;
    localparam int          WDHR_CMD_HALT       = 3;

    localparam int          WDHR_STATE_HALT_BIT = 16;
    localparam int          WDHR_STATE_SST_BIT  = 17;

    localparam int          WDHR_BASE_STAGES    = 8;
    localparam int          WDHR_PRE_STAGES     = 7;
    localparam int          WDHR_CNT_W          = WDHR_BASE_STAGES + WDHR_PRE_STAGES;
    localparam int          WDHR_BASE_DIV       = 256;

    localparam int          WDHR_INSTR_DIV      = 4;
    localparam int          WDHR_SST_CYCLES     = 1024;
    localparam int          WDHR_DLY_W          = 10;

    typedef enum logic [3:0] {
        ST_RUN     = 4'h1,
        ST_HALT    = 4'h2,
        ST_STARTUP = 4'h4,
        ST_IRQ_DLY = 4'h8
    } wdhr_mode_t;

    typedef struct packed {
        wdhr_mode_t              st;
        logic [7:0]              sel;
        logic                    to;
        logic                    pd;
        logic [WDHR_CNT_W-1:0]   cnt;
        logic [1:0]              div;
        logic                    first_seen;
        logic                    second_seen;
        logic [WDHR_DLY_W-1:0]   dly;
        logic                    wake_irq;
        logic [7:0]              pa_prev;
        logic                    chip_rst;
        logic                    warm_rst;
        logic                    run_start;
        logic                    irq_go;
        logic                    cpu_run;
        logic                    osc_run;
        logic                    waitreq;
        logic [31:0]             rdata;
    } wdhr_state_t;

    // Terminal count: base divider of 256 times prescaler ratio 2^sel, minus one.
    function automatic logic [WDHR_CNT_W-1:0] wdhr_wdt_limit(input logic [WDHR_RATIO_W-1:0] sel);
        wdhr_wdt_limit = (WDHR_CNT_W'(WDHR_BASE_DIV) << sel) - WDHR_CNT_W'(1);
    endfunction

endpackage

`default_nettype wire

// ---- src/wdhr_ctrl.sv ----
// Watchdog, halt and reset controller with an Avalon-MM register slave.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`default_nettype none

module wdhr_ctrl
    import wdhr_pkg::*;
#(
    parameter bit         WDT_ENABLE   = 1'b1,
    parameter bit         WDT_RC_OSC   = 1'b1,
    parameter bit         DUAL_CLEAR   = 1'b0,
    parameter bit         XTAL_SYSCLK  = 1'b1,
    parameter logic [7:0] PA_WAKE_MASK = 8'hFF
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        reset_pin_n_in,
    input  wire logic        wdt_osc_tick_in,
    input  wire logic        irq_in,
    input  wire logic        irq_enabled_in,
    input  wire logic        stack_full_in,
    input  wire logic [7:0]  port_a_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output var  logic [31:0] avs_readdata_out,
    output var  logic        avs_waitrequest_out,
    output var  logic        chip_reset_out,
    output var  logic        warm_reset_out,
    output var  logic        sys_osc_run_out,
    output var  logic        cpu_run_out,
    output var  logic        run_start_out,
    output var  logic        irq_take_out,
    output var  logic        timeout_flag_out,
    output var  logic        sleep_entered_flag_out
);

    wdhr_state_t q;
    wdhr_state_t n;

    logic                  inst_tick;
    logic                  wdt_tick;
    logic                  wdt_ovf;
    logic                  bus_wr;
    logic [7:0]            pa_fall;

    // An interrupt wake becomes an interrupt response only if the core can take it now.
    function automatic logic irq_taken(input logic woke_irq, input logic en, input logic full);
        irq_taken = woke_irq && en && !full;
    endfunction

    // The system oscillator is stopped in halt, so the instruction clock dies with it.
    assign inst_tick = (q.div == 2'(WDHR_INSTR_DIV - 1)) && (q.st != ST_HALT);
    assign wdt_tick  = WDT_ENABLE && (WDT_RC_OSC ? wdt_osc_tick_in : inst_tick);
    // Compare with at-or-above so that a smaller ratio written mid-period still times out
    // on the next tick instead of waiting for the whole counter to wrap.
    assign wdt_ovf   = wdt_tick && (q.cnt >= wdhr_wdt_limit(q.sel[WDHR_RATIO_W-1:0]));
    assign bus_wr    = avs_write_in && !q.waitreq && avs_byteenable_in[0];
    assign pa_fall   = q.pa_prev & ~port_a_in & PA_WAKE_MASK;

    always_comb begin
        logic clear_watchdog_single;
        logic halt_cmd;
        logic wake;
        clear_watchdog_single  = 1'b0;
        halt_cmd = 1'b0;
        wake     = 1'b0;
        n = q;
        n.pa_prev   = port_a_in;
        n.chip_rst  = 1'b0;
        n.warm_rst  = 1'b0;
        n.run_start = 1'b0;
        n.irq_go    = 1'b0;

        // Bus slave: every request waits exactly one cycle, then completes.
        n.waitreq = !((avs_read_in || avs_write_in) && q.waitreq);
        n.rdata   = 32'h0000_0000;
        if (avs_read_in && q.waitreq) begin
            unique case (avs_address_in)
                WDHR_OFS_SELECT: n.rdata[7:0] = q.sel;
                WDHR_OFS_STATUS: begin
                    n.rdata[WDHR_TO_BIT] = q.to;
                    n.rdata[WDHR_PD_BIT] = q.pd;
                end
                WDHR_OFS_STATE: begin
                    n.rdata[WDHR_CNT_W-1:0]      = q.cnt;
                    n.rdata[WDHR_STATE_HALT_BIT] = (q.st == ST_HALT);
                    n.rdata[WDHR_STATE_SST_BIT]  = (q.st == ST_STARTUP);
                end
                default: n.rdata = 32'h0000_0000;
            endcase
        end

        // Writes land on the edge at which waitrequest is seen low.
        if (bus_wr && avs_address_in == WDHR_OFS_SELECT) begin
            n.sel = avs_writedata_in[7:0];
        end
        // Clear commands come from a running program only; a halted or starting core issues none.
        if (bus_wr && avs_address_in == WDHR_OFS_COMMAND && WDT_ENABLE && (q.st == ST_RUN)) begin
            if (DUAL_CLEAR) begin
                n.first_seen  = q.first_seen || avs_writedata_in[WDHR_CMD_CLR_FIRST];
                n.second_seen = q.second_seen || avs_writedata_in[WDHR_CMD_CLR_SECOND];
                clear_watchdog_single = n.first_seen && n.second_seen;
            end else begin
                clear_watchdog_single = avs_writedata_in[WDHR_CMD_CLR_SINGLE];
            end
        end
        if (bus_wr && avs_address_in == WDHR_OFS_COMMAND) begin
            halt_cmd = avs_writedata_in[WDHR_CMD_HALT] && (q.st == ST_RUN);
        end

        // Instruction clock divider runs only while the system oscillator does.
        if (q.st != ST_HALT) begin
            n.div = q.div + 2'h1;
        end

        // Watchdog counter: base divider in the low eight bits, prescaler above.
        if (wdt_tick) begin
            n.cnt = q.cnt + WDHR_CNT_W'(1);
        end
        if (clear_watchdog_single) begin
            n.cnt         = '0;
            n.first_seen  = 1'b0;
            n.second_seen = 1'b0;
            n.to          = 1'b0;
            n.pd          = 1'b0;
        end

        // Start-up delay and interrupt delay share one counter.
        unique case (q.st)
            ST_RUN: begin
                if (halt_cmd) begin
                    n.st  = ST_HALT;
                    n.cnt = '0;
                    n.pd  = 1'b1;
                    n.to  = 1'b0;
                    n.div = 2'h0;
                end else if (wdt_ovf) begin
                    n.chip_rst = 1'b1;
                    n.to       = 1'b1;
                    n.cnt      = '0;
                    n.sel      = WDHR_SELECT_RESET;
                    n.div      = 2'h0;
                end
            end
            ST_HALT: begin
                n.wake_irq = 1'b0;
                if (wdt_ovf) begin
                    n.warm_rst = 1'b1;
                    n.to       = 1'b1;
                    n.cnt      = '0;
                    wake       = 1'b1;
                end else if (irq_in) begin
                    n.wake_irq = 1'b1;
                    wake       = 1'b1;
                end else if (|pa_fall) begin
                    wake = 1'b1;
                end
            end
            ST_STARTUP: begin
                n.dly = q.dly + WDHR_DLY_W'(1);
                if (q.dly == WDHR_DLY_W'(WDHR_SST_CYCLES - 1)) begin
                    n.dly = '0;
                    if (irq_taken(q.wake_irq, irq_enabled_in, stack_full_in)) begin
                        n.st = ST_IRQ_DLY;
                    end else begin
                        n.st        = ST_RUN;
                        n.run_start = 1'b1;
                    end
                end
            end
            ST_IRQ_DLY: begin
                n.dly = q.dly + WDHR_DLY_W'(1);
                if (q.dly == WDHR_DLY_W'(WDHR_INSTR_DIV - 1)) begin
                    n.dly       = '0;
                    n.st        = ST_RUN;
                    n.irq_go    = 1'b1;
                    n.run_start = 1'b1;
                end
            end
            default: n.st = ST_RUN;
        endcase

        // A crystal needs time to settle after halt; an RC oscillator runs at once.
        if (wake) begin
            n.dly = '0;
            if (XTAL_SYSCLK) begin
                n.st = ST_STARTUP;
            end else if (irq_taken(n.wake_irq, irq_enabled_in, stack_full_in)) begin
                n.st = ST_IRQ_DLY;
            end else begin
                n.st        = ST_RUN;
                n.run_start = 1'b1;
            end
        end

        // The reset pin wins over everything and skips the start-up delay.
        if (!reset_pin_n_in) begin
            n.st          = ST_RUN;
            n.chip_rst    = 1'b1;
            n.warm_rst    = 1'b0;
            n.run_start   = 1'b0;
            n.irq_go      = 1'b0;
            n.cnt         = '0;
            n.first_seen  = 1'b0;
            n.second_seen = 1'b0;
            n.sel         = WDHR_SELECT_RESET;
            n.div         = 2'h0;
            n.dly         = '0;
            n.wake_irq    = 1'b0;
            n.to          = q.to;
            n.pd          = q.pd;
        end
        if (q.st == ST_STARTUP && q.chip_rst && reset_pin_n_in && n.st == ST_STARTUP) begin
            n.chip_rst = 1'b1;
        end
        if (!WDT_ENABLE) begin
            n.cnt = '0;
        end
        n.cpu_run = (n.st == ST_RUN) && !n.chip_rst && !n.warm_rst;
        // The oscillator flag is registered so that the output comes straight from a flop.
        n.osc_run = (n.st != ST_HALT);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q.st          <= ST_STARTUP;
            q.sel         <= WDHR_SELECT_RESET;
            q.to          <= 1'b0;
            q.pd          <= 1'b0;
            q.cnt         <= '0;
            q.div         <= 2'h0;
            q.first_seen  <= 1'b0;
            q.second_seen <= 1'b0;
            q.dly         <= '0;
            q.wake_irq    <= 1'b0;
            q.pa_prev     <= 8'hFF;
            q.chip_rst    <= 1'b1;
            q.warm_rst    <= 1'b0;
            q.run_start   <= 1'b0;
            q.irq_go      <= 1'b0;
            q.cpu_run     <= 1'b0;
            q.osc_run     <= 1'b1;
            q.waitreq     <= 1'b1;
            q.rdata       <= 32'h0000_0000;
        end else begin
            q <= n;
        end
    end

    assign avs_readdata_out       = q.rdata;
    assign avs_waitrequest_out    = q.waitreq;
    assign chip_reset_out         = q.chip_rst;
    assign warm_reset_out         = q.warm_rst;
    assign sys_osc_run_out        = q.osc_run;
    assign cpu_run_out            = q.cpu_run;
    assign run_start_out          = q.run_start;
    assign irq_take_out           = q.irq_go;
    assign timeout_flag_out       = q.to;
    assign sleep_entered_flag_out = q.pd;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_halt_sets_flags: assert property (
        (q.st == ST_RUN) && (n.st == ST_HALT) |=> q.pd && !q.to && (q.cnt == '0) && !sys_osc_run_out
    ) else $error("halt entry did not set power-down, clear timeout and stop the oscillator");

    a_halt_clears_wdt: assert property (
        $rose(q.st == ST_HALT) |-> (q.cnt == '0) ##1 (q.cnt <= WDHR_CNT_W'(1))
    ) else $error("watchdog did not restart from zero after halt entry");

    a_overflow_run_reset: assert property (
        (q.st == ST_RUN) && wdt_ovf && reset_pin_n_in && (n.st == ST_RUN) |=> chip_reset_out && q.to
    ) else $error("run-time overflow did not reset the chip and set timeout");

    a_overflow_halt_warm: assert property (
        (q.st == ST_HALT) && wdt_ovf && reset_pin_n_in |=> warm_reset_out && q.to && q.pd && !chip_reset_out
    ) else $error("halted overflow did not give a warm reset with both flags set");

    a_pin_clears_wdt: assert property (
        !reset_pin_n_in |=> (q.cnt == '0) && chip_reset_out && (q.sel == WDHR_SELECT_RESET)
    ) else $error("reset pin did not clear the watchdog and select register");

    a_pin_keeps_flags: assert property (
        !reset_pin_n_in |=> (q.to == $past(q.to)) && (q.pd == $past(q.pd))
    ) else $error("reset pin changed the reset cause flags");

    a_startup_length: assert property (
        (q.st == ST_STARTUP) && (q.dly != '0)
        |-> ($past(q.st) == ST_STARTUP) && (q.dly == $past(q.dly) + WDHR_DLY_W'(1))
    ) else $error("start-up delay counter skipped or restarted a count");

    a_startup_leaves: assert property (
        (q.st == ST_STARTUP) && (q.dly == WDHR_DLY_W'(WDHR_SST_CYCLES - 1)) && reset_pin_n_in
        |=> (q.st != ST_STARTUP)
    ) else $error("start-up delay did not end after its last count");

    a_irq_extra_cycle: assert property (
        $rose(q.st == ST_IRQ_DLY) |-> !irq_take_out [*4] ##1 (irq_take_out || !reset_pin_n_in || $past(!reset_pin_n_in))
    ) else $error("interrupt after wake was not delayed by one instruction cycle");

    a_select_write: assert property (
        bus_wr && (avs_address_in == WDHR_OFS_SELECT) && reset_pin_n_in && !(wdt_ovf && q.st == ST_RUN)
        |=> (q.sel == $past(avs_writedata_in[7:0]))
    ) else $error("select register did not store the written byte");

    a_disabled_idle: assert property (
        !WDT_ENABLE |-> (q.cnt == '0) && !warm_reset_out
    ) else $error("disabled watchdog counted or reset");

    // Command, counting, wake, reset-hold and bus paths.
    a_clear_single: assert property (
        bus_wr && (avs_address_in == WDHR_OFS_COMMAND) && avs_writedata_in[WDHR_CMD_CLR_SINGLE]
        && !avs_writedata_in[WDHR_CMD_HALT] && !DUAL_CLEAR && WDT_ENABLE && (q.st == ST_RUN)
        && reset_pin_n_in && !wdt_ovf |=> (q.cnt == '0) && !q.to && !q.pd
    ) else $error("single clear command did not clear the watchdog and flags");

    a_count_step: assert property (
        (q.st == ST_RUN) && wdt_tick && !wdt_ovf && reset_pin_n_in
        && !(bus_wr && (avs_address_in == WDHR_OFS_COMMAND))
        |=> (q.cnt == $past(q.cnt) + WDHR_CNT_W'(1))
    ) else $error("watchdog counter did not advance on its tick");

    a_port_wake: assert property (
        (q.st == ST_HALT) && (|pa_fall) |=> (q.st != ST_HALT)
    ) else $error("enabled port falling edge did not end halt");

    a_irq_wake: assert property (
        (q.st == ST_HALT) && irq_in |=> (q.st != ST_HALT)
    ) else $error("interrupt request did not end halt");

    a_wake_resume: assert property (
        run_start_out |-> (q.st == ST_RUN) && !chip_reset_out
    ) else $error("execution resumed outside the run state");

    a_cpu_held: assert property (
        (q.st != ST_RUN) |-> !cpu_run_out
    ) else $error("core ran during halt or a wake delay");

    a_chip_held_startup: assert property (
        (q.st == ST_STARTUP) && chip_reset_out && reset_pin_n_in |=> chip_reset_out || (q.st != ST_STARTUP)
    ) else $error("chip reset dropped before the power-up delay ended");

    a_warm_only_halt: assert property (
        warm_reset_out |-> ($past(q.st) == ST_HALT)
    ) else $error("warm reset issued outside halt");

    a_status_read: assert property (
        avs_read_in && avs_waitrequest_out && (avs_address_in == WDHR_OFS_STATUS)
        |=> (avs_readdata_out[WDHR_TO_BIT] == $past(q.to)) && (avs_readdata_out[WDHR_PD_BIT] == $past(q.pd))
    ) else $error("status read did not return the timeout and power-down flags");

    a_rdata_idle: assert property (
        avs_waitrequest_out |-> (avs_readdata_out == 32'h0000_0000)
    ) else $error("read data shown outside the answer cycle");

    a_bus_answer: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out
    ) else $error("bus request not answered after one wait cycle");

    c_halt_entry: cover property ((q.st == ST_RUN) ##1 (q.st == ST_HALT));
    c_halt_overflow: cover property ((q.st == ST_HALT) ##1 warm_reset_out);
    c_irq_wake: cover property ((q.st == ST_IRQ_DLY) ##[1:8] irq_take_out);
    c_port_wake: cover property ((q.st == ST_HALT) && (|pa_fall) && !irq_in);
    c_run_overflow: cover property ((q.st == ST_RUN) && wdt_ovf && reset_pin_n_in);

endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench of the watchdog, halt and reset controller.
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    import wdhr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_in;
    logic        rst_in;
    logic        pin_n;
    logic        tick;
    logic        tick_en;
    logic        irq;
    logic        irq_en;
    logic        stk_full;
    logic [7:0]  port_a;
    logic [3:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdat_o;
    logic        wrq;
    logic        chip_rst;
    logic        warm_rst;
    logic        osc_run;
    logic        cpu_run;
    logic        run_start;
    logic        irq_take;
    logic        to_flag;
    logic        pd_flag;
    int          n_fail;
    int          num_checks;
    logic [31:0] q;
    int          n;

    wdhr_ctrl DUT (
        .clk_in                 (clk_in),
        .rst_in                 (rst_in),
        .reset_pin_n_in         (pin_n),
        .wdt_osc_tick_in        (tick),
        .irq_in                 (irq),
        .irq_enabled_in         (irq_en),
        .stack_full_in          (stk_full),
        .port_a_in              (port_a),
        .avs_address_in         (addr),
        .avs_read_in            (rd),
        .avs_write_in           (wr),
        .avs_writedata_in       (wdata),
        .avs_byteenable_in      (be),
        .avs_readdata_out       (rdat_o),
        .avs_waitrequest_out    (wrq),
        .chip_reset_out         (chip_rst),
        .warm_reset_out         (warm_rst),
        .sys_osc_run_out        (osc_run),
        .cpu_run_out            (cpu_run),
        .run_start_out          (run_start),
        .irq_take_out           (irq_take),
        .timeout_flag_out       (to_flag),
        .sleep_entered_flag_out (pd_flag)
    );

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // The oscillator tick runs at half the system rate so overflows stay short.
    always @(posedge clk_in) begin
        tick <= tick_en & ~tick;
    end

    function automatic logic sig(input int k);
        case (k)
            0: sig = run_start;
            1: sig = chip_rst;
            2: sig = warm_rst;
            3: sig = irq_take;
            default: sig = cpu_run;
        endcase
    endfunction

    task automatic wait_for(input int k, input int lim, output int cnt);
        cnt = 0;
        while (sig(k) !== 1'b1 && cnt < lim) begin
            @(posedge clk_in);
            cnt++;
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_in);
        addr  <= a;
        wr    <= w;
        rd    <= ~w;
        wdata <= d;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (wrq !== 1'b0 && k < 20);
        r = rdat_o;
        wr <= 1'b0;
        rd <= 1'b0;
        `CHK("bus answer", 1'b1, k < 20)
    endtask

    task automatic end_sim();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic t_powerup();
        `CHK("reset held", 1'b1, chip_rst)
        bus(1'b0, WDHR_OFS_STATE, 32'h0, q);
        `CHK("state startup", 32'h0002_0000, q)
        wait_for(0, 1100, n);
        `CHK("startup len", 1'b1, n >= 1020 && n <= 1027)
        bus(1'b0, WDHR_OFS_SELECT, 32'h0, q);
        `CHK("select reset", 32'h07, q)
        bus(1'b0, WDHR_OFS_STATUS, 32'h0, q);
        `CHK("status power-up", 32'h00, q)
    endtask

    task automatic t_regs();
        bus(1'b1, WDHR_OFS_SELECT, 32'hA8, q);
        bus(1'b0, WDHR_OFS_SELECT, 32'h0, q);
        `CHK("select user bits", 32'hA8, q)
        bus(1'b1, WDHR_OFS_STATUS, 32'hFF, q);
        bus(1'b0, WDHR_OFS_STATUS, 32'h0, q);
        `CHK("status read-only", 32'h00, q)
        bus(1'b0, 4'h2, 32'h0, q);
        `CHK("unmapped read", 32'h00, q)
    endtask

    // A clear about 400 cycles into the 512-cycle period must push the overflow out.
    task automatic t_clear_run();
        int hits;
        tick_en <= 1'b1;
        repeat (400) @(posedge clk_in);
        bus(1'b1, WDHR_OFS_COMMAND, 32'h01, q);
        hits = 0;
        repeat (400) begin
            @(posedge clk_in);
            hits += int'(chip_rst === 1'b1);
        end
        `CHK("no early overflow", 0, hits)
        wait_for(1, 200, n);
        `CHK("run overflow reset", 1'b1, chip_rst)
        tick_en <= 1'b0;
        bus(1'b0, WDHR_OFS_STATUS, 32'h0, q);
        `CHK("status run timeout", 32'h20, q)
        bus(1'b0, WDHR_OFS_SELECT, 32'h0, q);
        `CHK("select after reset", 32'h07, q)
    endtask

    task automatic halt();
        bus(1'b1, WDHR_OFS_COMMAND, 32'h08, q);
        @(posedge clk_in);
        `CHK("halt pd", 1'b1, pd_flag)
        `CHK("halt to", 1'b0, to_flag)
        `CHK("halt osc", 1'b0, osc_run)
        `CHK("halt cpu", 1'b0, cpu_run)
    endtask

    task automatic t_halt_port();
        int hits;
        bus(1'b1, WDHR_OFS_SELECT, 32'hA0, q);
        halt();
        bus(1'b0, WDHR_OFS_STATE, 32'h0, q);
        `CHK("state halted", 32'h0001_0000, q)
        port_a <= 8'hF7;
        hits = 0;
        n = 0;
        while (run_start !== 1'b1 && n < 1100) begin
            @(posedge clk_in);
            n++;
            hits += int'(irq_take === 1'b1);
        end
        `CHK("port wake delay", 1'b1, n >= 1020 && n <= 1030)
        `CHK("port wake no irq", 0, hits)
        port_a <= 8'hFF;
    endtask

    task automatic t_halt_wdt();
        tick_en <= 1'b1;
        halt();
        wait_for(2, 700, n);
        tick_en <= 1'b0;
        `CHK("halt overflow time", 1'b1, n >= 500 && n <= 530)
        `CHK("warm not chip", 1'b0, chip_rst)
        @(posedge clk_in);
        `CHK("wdt wake flags", 2'b11, {to_flag, pd_flag})
        wait_for(0, 1100, n);
        `CHK("wdt wake resume", 1'b1, run_start)
        bus(1'b0, WDHR_OFS_SELECT, 32'h0, q);
        `CHK("select kept", 32'hA0, q)
    endtask

    task automatic t_halt_irq();
        halt();
        irq_en <= 1'b1;
        irq    <= 1'b1;
        wait_for(3, 1100, n);
        `CHK("irq take", 1'b1, irq_take)
        `CHK("irq delay", 1'b1, n >= 1024 && n <= 1034)
        irq    <= 1'b0;
        irq_en <= 1'b0;
    endtask

    task automatic t_pin_halt();
        halt();
        pin_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        `CHK("pin reset", 1'b1, chip_rst)
        pin_n <= 1'b1;
        wait_for(4, 6, n);
        `CHK("pin no startup", 1'b1, n <= 3)
        bus(1'b0, WDHR_OFS_STATUS, 32'h0, q);
        `CHK("pin wake flags", 32'h10, q)
        bus(1'b0, WDHR_OFS_SELECT, 32'h0, q);
        `CHK("pin select", 32'h07, q)
    endtask

    initial begin
        #(50 * 20000);
        `CHK("run time", 1'b0, 1'b1)
        end_sim();
    end

    initial begin
        n_fail = 0;
        num_checks = 0;
        rst_in = 1'b1;
        pin_n = 1'b1;
        tick_en = 1'b0;
        irq = 1'b0;
        irq_en = 1'b0;
        stk_full = 1'b0;
        port_a = 8'hFF;
        addr = 4'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'hF;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        t_powerup();
        t_regs();
        t_clear_run();
        t_halt_port();
        t_halt_wdt();
        t_halt_irq();
        t_pin_halt();
        end_sim();
    end
endmodule

`default_nettype wire
